// *** rr_exec_pkg.sv ***
// shared constants and types for the return and rotate execution block
package rr_exec_pkg;

  // =====================================================
  // widths
  localparam int DATA_W = 8;
  localparam int PC_W = 15;

  // =====================================================
  // reset values
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // =====================================================
  // timing counts, in instruction cycles
  localparam int RETURN_CYCLES = 2;
  localparam int ROTATE_CYCLES = 1;

  // =====================================================
  // decoded operation codes seen on the issue port
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_RETURN = 3'h1;
  localparam logic [2:0] OP_RETURN_WITH_LITERAL = 3'h2;
  localparam logic [2:0] OP_ROTATE_LEFT = 3'h3;
  localparam logic [2:0] OP_ROTATE_RIGHT = 3'h4;

  // =====================================================
  // destination-select encoding
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic {
    ST_ISSUE,
    ST_RETURN_FLUSH
  } exec_state_t;

endpackage

// *** rotate_through_carry.sv ***
// one-bit rotate of an 8-bit operand through the carry flag
`timescale 1ns/1ps

module rotate_through_carry (
  // operand
  input wire logic [rr_exec_pkg::DATA_W-1:0] operand,
  input wire logic carry_in,
  input wire logic to_left,
  // result
  output logic [rr_exec_pkg::DATA_W-1:0] result,
  output logic carry_out
);

  // =====================================================
  // rotate
  always_comb begin
    if (to_left) begin
      result = {operand[rr_exec_pkg::DATA_W-2:0], carry_in};
      carry_out = operand[rr_exec_pkg::DATA_W-1];
    end else begin
      result = {carry_in, operand[rr_exec_pkg::DATA_W-1:1]};
      carry_out = operand[0];
    end
  end

endmodule

// *** return_and_rotate_exec.sv ***
// execution of return, return with literal and the two rotate-through-carry operations
`timescale 1ns/1ps

module return_and_rotate_exec (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // issue port from decode
  input wire logic EXEC_VALID,
  input wire logic [2:0] EXEC_OP,
  input wire logic [rr_exec_pkg::DATA_W-1:0] EXEC_LITERAL,
  input wire logic EXEC_DEST,
  output logic EXEC_READY,
  // operand and flag inputs
  input wire logic [rr_exec_pkg::DATA_W-1:0] FILE_RDATA,
  input wire logic CARRY_IN,
  input wire logic [rr_exec_pkg::PC_W-1:0] STACK_TOP_ENTRY,
  // program counter and stack
  output logic STACK_POP,
  output logic PC_LOAD,
  output logic [rr_exec_pkg::PC_W-1:0] PC_VALUE,
  output logic FETCH_FLUSH,
  // accumulator
  output logic ACC_WE,
  output logic [rr_exec_pkg::DATA_W-1:0] ACC_WDATA,
  // data memory write back
  output logic FILE_WE,
  output logic [rr_exec_pkg::DATA_W-1:0] FILE_WDATA,
  // status flags
  output logic CARRY_WE,
  output logic CARRY_OUT
);

  // sequencing state
  rr_exec_pkg::exec_state_t state_q;
  rr_exec_pkg::exec_state_t state_d;
  logic ready_q;
  // registered outputs
  logic pop_q;
  logic pc_load_q;
  logic [rr_exec_pkg::PC_W-1:0] pc_value_q;
  logic flush_q;
  logic acc_we_q;
  logic [rr_exec_pkg::DATA_W-1:0] acc_wdata_q;
  logic file_we_q;
  logic [rr_exec_pkg::DATA_W-1:0] file_wdata_q;
  logic carry_we_q;
  logic carry_out_q;
  // rotate unit and decode
  logic [rr_exec_pkg::DATA_W-1:0] rot_result;
  logic rot_carry;
  logic take;
  logic is_return;
  logic is_rotate;
  logic is_literal_return;

  // =====================================================
  // decode
  function automatic logic op_is_return(input logic [2:0] op);
    op_is_return = (op == rr_exec_pkg::OP_RETURN) ||
                   (op == rr_exec_pkg::OP_RETURN_WITH_LITERAL);
  endfunction

  function automatic logic op_is_rotate(input logic [2:0] op);
    op_is_rotate = (op == rr_exec_pkg::OP_ROTATE_LEFT) ||
                   (op == rr_exec_pkg::OP_ROTATE_RIGHT);
  endfunction

  // ready gates taking: requests in the flush cycle or right after reset are dropped, not queued
  assign take = EXEC_VALID && ready_q;
  assign is_return = take && op_is_return(EXEC_OP);
  assign is_literal_return = take && (EXEC_OP == rr_exec_pkg::OP_RETURN_WITH_LITERAL);
  assign is_rotate = take && op_is_rotate(EXEC_OP);

  rotate_through_carry u_rot (
    .operand(FILE_RDATA),
    .carry_in(CARRY_IN),
    .to_left(EXEC_OP == rr_exec_pkg::OP_ROTATE_LEFT),
    .result(rot_result),
    .carry_out(rot_carry)
  );

  // =====================================================
  // sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      rr_exec_pkg::ST_ISSUE: begin
        if (is_return) begin
          state_d = rr_exec_pkg::ST_RETURN_FLUSH;
        end
      end
      rr_exec_pkg::ST_RETURN_FLUSH: begin
        state_d = rr_exec_pkg::ST_ISSUE;
      end
      default: begin
        state_d = rr_exec_pkg::ST_ISSUE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_q <= rr_exec_pkg::ST_ISSUE;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================
  // issue readiness
  // low through reset and its first cycle out, so nothing is taken before state settles
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_d == rr_exec_pkg::ST_ISSUE);
    end
  end

  // =====================================================
  // stack and fetch strobes
  // one-cycle pulses; the outer pipeline acts on them at the next edge
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pop_q <= 1'b0;
      pc_load_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      pop_q <= is_return;
      pc_load_q <= is_return;
      flush_q <= is_return;
    end
  end

  // =====================================================
  // program counter value
  // held between returns so the counter logic may read it with the load strobe
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pc_value_q <= rr_exec_pkg::PC_RST;
    end else if (is_return) begin
      pc_value_q <= STACK_TOP_ENTRY;
    end
  end

  // =====================================================
  // accumulator write
  // a literal return and a rotate are never taken together, so one source wins
  always_ff @(posedge MCLK) begin
    if (RST) begin
      acc_we_q <= 1'b0;
      acc_wdata_q <= rr_exec_pkg::DATA_RST;
    end else begin
      acc_we_q <= 1'b0;
      if (is_literal_return) begin
        acc_we_q <= 1'b1;
        acc_wdata_q <= EXEC_LITERAL;
      end else if (is_rotate && EXEC_DEST == rr_exec_pkg::DEST_ACC) begin
        acc_we_q <= 1'b1;
        acc_wdata_q <= rot_result;
      end
    end
  end

  // =====================================================
  // data memory write back
  always_ff @(posedge MCLK) begin
    if (RST) begin
      file_we_q <= 1'b0;
      file_wdata_q <= rr_exec_pkg::DATA_RST;
    end else begin
      file_we_q <= 1'b0;
      if (is_rotate && EXEC_DEST == rr_exec_pkg::DEST_FILE) begin
        file_we_q <= 1'b1;
        file_wdata_q <= rot_result;
      end
    end
  end

  // =====================================================
  // status flags
  // only carry has a write strobe; zero and digit carry are never touched here
  always_ff @(posedge MCLK) begin
    if (RST) begin
      carry_we_q <= 1'b0;
      carry_out_q <= 1'b0;
    end else begin
      carry_we_q <= is_rotate;
      if (is_rotate) begin
        carry_out_q <= rot_carry;
      end
    end
  end

  // =====================================================
  // outputs
  // issue and program counter
  assign EXEC_READY = ready_q;
  assign STACK_POP = pop_q;
  assign PC_LOAD = pc_load_q;
  assign PC_VALUE = pc_value_q;
  assign FETCH_FLUSH = flush_q;

  // write strobes and data
  assign ACC_WE = acc_we_q;
  assign ACC_WDATA = acc_wdata_q;
  assign FILE_WE = file_we_q;
  assign FILE_WDATA = file_wdata_q;
  assign CARRY_WE = carry_we_q;
  assign CARRY_OUT = carry_out_q;

endmodule

// *** rr_exec_asserts.sv ***
// checker for the return and rotate execution block
`timescale 1ns/1ps

module rr_exec_asserts (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // issue port
  input wire logic EXEC_VALID,
  input wire logic [2:0] EXEC_OP,
  input wire logic [rr_exec_pkg::DATA_W-1:0] EXEC_LITERAL,
  input wire logic EXEC_DEST,
  input wire logic EXEC_READY,
  // operand and flag inputs
  input wire logic [rr_exec_pkg::DATA_W-1:0] FILE_RDATA,
  input wire logic CARRY_IN,
  input wire logic [rr_exec_pkg::PC_W-1:0] STACK_TOP_ENTRY,
  // program counter and stack
  input wire logic STACK_POP,
  input wire logic PC_LOAD,
  input wire logic [rr_exec_pkg::PC_W-1:0] PC_VALUE,
  input wire logic FETCH_FLUSH,
  // write back
  input wire logic ACC_WE,
  input wire logic [rr_exec_pkg::DATA_W-1:0] ACC_WDATA,
  input wire logic FILE_WE,
  input wire logic [rr_exec_pkg::DATA_W-1:0] FILE_WDATA,
  // status flags
  input wire logic CARRY_WE,
  input wire logic CARRY_OUT
);
  // =====================================================
  // helpers
  logic tk;
  logic rt;
  logic rw;
  logic rl;
  logic rr;
  logic [rr_exec_pkg::DATA_W-1:0] res;
  assign tk = EXEC_VALID && EXEC_READY;
  assign rt = tk && EXEC_OP == rr_exec_pkg::OP_RETURN;
  assign rw = tk && EXEC_OP == rr_exec_pkg::OP_RETURN_WITH_LITERAL;
  assign rl = tk && EXEC_OP == rr_exec_pkg::OP_ROTATE_LEFT;
  assign rr = tk && EXEC_OP == rr_exec_pkg::OP_ROTATE_RIGHT;
  // whichever write strobe fired carries the rotated value
  assign res = FILE_WE ? FILE_WDATA : ACC_WDATA;

  // =====================================================
  // properties
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RST);
  property p_pop;
    rt || rw |=> STACK_POP && PC_LOAD && PC_VALUE == $past(STACK_TOP_ENTRY);
  endproperty
  a_pop: assert property (p_pop) else $error("counter not reloaded");
  property p_two;
    rt || rw |=> FETCH_FLUSH && !EXEC_READY ##1 EXEC_READY && !STACK_POP;
  endproperty
  a_two: assert property (p_two) else $error("return length wrong");
  property p_lit;
    rw |=> ACC_WE && ACC_WDATA == $past(EXEC_LITERAL);
  endproperty
  a_lit: assert property (p_lit) else $error("literal not written");
  property p_lw2;
    rw |=> !EXEC_READY ##1 EXEC_READY && !ACC_WE && !PC_LOAD;
  endproperty
  a_lw2: assert property (p_lw2) else $error("literal return length wrong");
  property p_rl;
    rl |=> CARRY_WE && {CARRY_OUT, res} == {$past(FILE_RDATA), $past(CARRY_IN)};
  endproperty
  a_rl: assert property (p_rl) else $error("left rotate wrong");
  property p_rr;
    rr |=> CARRY_WE && {res, CARRY_OUT} == {$past(CARRY_IN), $past(FILE_RDATA)};
  endproperty
  a_rr: assert property (p_rr) else $error("right rotate wrong");
  property p_dst;
    rl || rr |=> FILE_WE == $past(EXEC_DEST) && ACC_WE != $past(EXEC_DEST);
  endproperty
  a_dst: assert property (p_dst) else $error("wrong destination");
  property p_flg;
    tk |=> CARRY_WE == ($past(rl) || $past(rr)) && EXEC_READY == !($past(rt) || $past(rw));
  endproperty
  a_flg: assert property (p_flg) else $error("flag or length wrong");
  property p_ret;
    rt |=> !ACC_WE && !FILE_WE && !CARRY_WE;
  endproperty
  a_ret: assert property (p_ret) else $error("plain return wrote data or flags");
  c_rw: cover property (rw);
  c_rr: cover property (rr);
  c_ref: cover property (rt ##2 tk);
endmodule

bind return_and_rotate_exec rr_exec_asserts u_rr_exec_asserts (.*);

// *** testbench.sv ***
// self-checking bench for the return and rotate execution block
`timescale 1ns/1ps

module testbench;
  // =====
  // stimulus and checks
  localparam logic [2:0] ret = rr_exec_pkg::OP_RETURN;
  localparam logic [2:0] rwl = rr_exec_pkg::OP_RETURN_WITH_LITERAL;
  localparam logic [2:0] rol = rr_exec_pkg::OP_ROTATE_LEFT;
  localparam logic [2:0] ror = rr_exec_pkg::OP_ROTATE_RIGHT;
  logic MCLK = 1'h0, RST = 1'h1, EXEC_VALID = 1'h0, EXEC_DEST = 1'h0, CARRY_IN = 1'h0;
  logic [2:0] EXEC_OP = 3'h0;
  logic [7:0] EXEC_LITERAL = 8'h00, FILE_RDATA = 8'h00, ACC_WDATA, FILE_WDATA;
  logic [14:0] STACK_TOP_ENTRY = 15'h0000, PC_VALUE;
  logic EXEC_READY, STACK_POP, PC_LOAD, FETCH_FLUSH, ACC_WE, FILE_WE, CARRY_WE, CARRY_OUT;
  int mismatches = 0, cmp_count = 0;
  always #10 MCLK = ~MCLK;
  return_and_rotate_exec u_return_and_rotate_exec (.*);

  task report_and_stop;
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one value feeds literal, operand and stack top so each field is traceable;
  // hold offers a left rotate to the source right away, into the refused cycle
  task issue(input logic [2:0] op, input logic [7:0] v, input logic d, input logic c,
             input logic hold);
    int n;
    @(posedge MCLK);
    EXEC_VALID <= 1'h1;
    EXEC_OP <= op;
    EXEC_LITERAL <= v;
    FILE_RDATA <= v;
    EXEC_DEST <= d;
    CARRY_IN <= c;
    STACK_TOP_ENTRY <= {~v[6:0], v};
    n = 0;
    #1;
    while (EXEC_READY !== 1'h1 && n < 8) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    if (n == 8) begin
      mismatches++;
      report_and_stop;
    end
    @(posedge MCLK);
    EXEC_VALID <= hold;
    EXEC_OP <= hold ? rol : op;
    EXEC_DEST <= hold | d;
    #1;
  endtask

  // a return, then a rotate offered in the refused cycle and held until taken
  task t_ret(input logic [2:0] op, input logic [7:0] k);
    issue(op, k, 1'h0, 1'h1, 1'h1);
    chk({STACK_POP, PC_LOAD, FETCH_FLUSH, PC_VALUE}, {3'h7, ~k[6:0], k});
    chk({ACC_WE, ACC_WE ? ACC_WDATA : k}, {op == rwl, k});
    chk({CARRY_WE, FILE_WE, EXEC_READY}, 3'h0);
    @(posedge MCLK);
    #1;
    chk({FILE_WE, STACK_POP, EXEC_READY}, 3'h1);
    @(posedge MCLK);
    EXEC_VALID <= 1'h0;
    #1;
    chk({FILE_WE, FILE_WDATA}, {1'h1, k[6:0], 1'h1});
  endtask

  task t_rot(input logic [2:0] op, input logic [7:0] v, input logic d, input logic c);
    logic [8:0] e;
    e = (op == rol) ? {v, c} : {v[0], c, v[7:1]};
    issue(op, v, d, c, 1'h0);
    chk({CARRY_WE, CARRY_OUT, d ? FILE_WDATA : ACC_WDATA}, {1'h1, e});
    chk({ACC_WE, FILE_WE, EXEC_READY, STACK_POP}, {~d, d, 2'h2});
  endtask

  initial begin
    repeat (16) @(posedge MCLK);
    RST <= 1'h0;
    // a return offered while ready is still low must be refused
    EXEC_VALID <= 1'h1;
    EXEC_OP <= ret;
    @(posedge MCLK);
    EXEC_VALID <= 1'h0;
    #1;
    chk({EXEC_READY, STACK_POP, PC_VALUE}, 17'h10000);
    t_ret(ret, 8'h3C);
    t_ret(rwl, 8'hFF);
    t_ret(rwl, 8'h00);
    for (int i = 0; i < 8; i++)
      t_rot(i[0] ? ror : rol, i[1] ? 8'h19 : 8'hE6, i[2], i[1]);
    report_and_stop;
  end
endmodule
